/* src/stp_pkg.sv */
/*
 Shared constants and types of the SMBus target block: addresses, timing
 counts, register map of the bus slave, state encoding and the state struct.
 Assumes a 100 MHz system clock.
*/
package stp_pkg;

   // Bus addresses and the alert-response reply
   localparam logic [6:0] STP_DEV_ADDR = 7'h4c;  // Own target address
   localparam logic [6:0] STP_ARA_ADDR = 7'h0c;  // Alert response address
   localparam logic [7:0] STP_ARA_RESP = 8'h98;  // Own address plus zero bit

   // Timing, each figure in ms and then in clock cycles
   localparam int STP_CLK_KHZ   = 100000;
   localparam int STP_PWRUP_MS  = 15;
   localparam int STP_TOUT_MS   = 30;
   localparam int STP_PWRUP_CYC = STP_PWRUP_MS * STP_CLK_KHZ;
   localparam int STP_TOUT_CYC  = STP_TOUT_MS * STP_CLK_KHZ;

   // Register byte offsets
   localparam logic [7:0] STP_REG_CTRL = 8'h00;  // Timeout enable, alert mask
   localparam logic [7:0] STP_REG_STAT = 8'h04;  // Sticky status, write 1 clears
   localparam logic [7:0] STP_REG_PTR  = 8'h08;  // Pointer and protocol state

   // Control field positions
   localparam int STP_CTRL_TOUT = 0;
   localparam int STP_CTRL_MASK = 1;

   // Protocol states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,  // Waiting for START
      ST_ADDR = 3'b001,  // Shifting address byte
      ST_AACK = 3'b010,  // Driving address acknowledge
      ST_RX   = 3'b011,  // Receiving a byte
      ST_RACK = 3'b100,  // Driving byte acknowledge
      ST_TX   = 3'b101,  // Sending a byte
      ST_TACK = 3'b110,  // Sampling host acknowledge
      ST_WAIT = 3'b111   // Ignoring bus until START or STOP
   } stp_state_t;

   // Classic Wishbone request
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } stp_wb_req_t;

   // Whole state of the target
   typedef struct packed {
      logic [2:0]  scl_s;     // Clock pin synchroniser
      logic [2:0]  sda_s;     // Data pin synchroniser
      logic        scl_f;     // Filtered clock level
      logic        sda_f;     // Filtered data level
      stp_state_t  st;        // Protocol state
      logic [3:0]  cnt;       // Bit counter
      logic [7:0]  sr;        // Receive shifter
      logic [7:0]  tx;        // Transmit shifter
      logic [1:0]  byte_idx;  // Bytes taken after address
      logic        is_ara;    // Current read is alert response
      logic        rnw;       // Read transfer
      logic        sda_oe;    // Pulling data line low
      logic [7:0]  ptr;       // Register pointer
      logic        wr;        // Register write strobe
      logic        rd;        // Register read strobe
      logic [7:0]  wdata;     // Register write data
      logic        tout_en;   // Timeout enable
      logic        mask;      // Alert mask
      logic [7:0]  status;    // Sticky alert status
      logic        alert;     // Alert pin pulled low
      logic [21:0] tcnt;      // Clock-low counter
      logic [21:0] pcnt;      // Power-up counter
      logic        ready;     // Power-up window over
      logic        wb_ack;    // Bus acknowledge
      logic [31:0] wb_dat;    // Bus read data
   } stp_regs_t;

   // Reset state; pin filters start at the idle-high level, so no false edge follows reset
   localparam stp_regs_t STP_REGS_RST = '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
                                          st: ST_IDLE, default: '0};

endpackage : stp_pkg

/* src/stp_smbus_target.sv */
/*
 SMBus target with alert response, timeout and power-up window.
 Assumes the host drives the clock pin, the bench resolves the open-drain
 wires from the enables, and an outer register map answers reg_rdata_i
 combinationally for reg_ptr_o.
*/
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
// Behaviour
// RULE1 - Ignore bus for 15 ms after reset
// RULE2 - Accept send, receive, read, write, alert response
// RULE3 - Wrong address or protocol: no ack, no change
// RULE4 - Follow real clock edges, tolerate stretching
// RULE5 - Write Byte stores data into addressed register
// RULE6 - Read Byte returns addressed register byte
// RULE7 - Send Byte loads pointer only
// RULE8 - Receive Byte reads register at pointer
// RULE9 - Answer only fixed address 1001_100
// RULE10 - Alert pin serves interrupt or SMBus alert
// RULE11 - Host reads alert response address after alert
// RULE12 - Active alert answers ARA with 1001_1000
// RULE13 - Check each sent bit for arbitration loss
// RULE14 - Complete alert response sets alert mask
// RULE15 - Alert response leaves status flags alone
// RULE16 - Clock low over 30 ms resets protocol
// RULE17 - Timeout only when timeout enable set
// RULE18 - Alert holds until status flags cleared
// RULE19 - Timeout releases data, keeps registers
// RULE20 - Register address byte also updates pointer
`timescale 1ns/1ns
module stp_smbus_target #(
   parameter int PWRUP_CYC = stp_pkg::STP_PWRUP_CYC,
   parameter int TOUT_CYC  = stp_pkg::STP_TOUT_CYC
) (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // Wishbone slave
   input  wire stp_pkg::stp_wb_req_t wb_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o,
   // Bus pins
   input  wire logic                serial_clock_pin_i,
   input  wire logic                serial_data_pin_i,
   output logic                     serial_data_pin_o,
   output logic                     serial_data_pin_oe_o,
   output logic                     alert_pin_o,
   output logic                     alert_pin_oe_o,
   // Outer register map
   output logic [7:0]               reg_ptr_o,
   output logic                     reg_wr_o,
   output logic                     reg_rd_o,
   output logic [7:0]               reg_wdata_o,
   input  wire logic [7:0]          reg_rdata_i,
   // Out-of-limit events
   input  wire logic [7:0]          alert_event_i
);
   import stp_pkg::*;

   stp_regs_t  r;         // Registered state
   stp_regs_t  n;         // Next state
   logic       rise;      // Clock rising edge
   logic       fall;      // Clock falling edge
   logic       start;     // START seen
   logic       stop;      // STOP seen
   logic       tout;      // Clock-low timeout
   logic       ara_done;  // Alert response finished uncontested
   logic       bus_req;   // New bus access
   logic [7:0] clr;       // Status bits written with one

   // Next-state logic
   always_comb begin
      n        = r;
      n.wr     = 1'b0;
      n.rd     = 1'b0;
      n.wb_ack = 1'b0;
      ara_done = 1'b0;
      clr      = 8'h00;
      // Three-stage sync; a level counts once stages two and three agree
      n.scl_s  = {r.scl_s[1:0], serial_clock_pin_i};
      n.sda_s  = {r.sda_s[1:0], serial_data_pin_i};
      if (r.scl_s[1] == r.scl_s[2]) begin
         n.scl_f = r.scl_s[2];
      end
      if (r.sda_s[1] == r.sda_s[2]) begin
         n.sda_f = r.sda_s[2];
      end
      // Edges follow the real clock level, so stretching is harmless
      rise  = ~r.scl_f & n.scl_f;  // RULE4
      fall  = r.scl_f & ~n.scl_f;  // RULE4
      start = r.scl_f & n.scl_f & r.sda_f & ~n.sda_f;
      stop  = r.scl_f & n.scl_f & ~r.sda_f & n.sda_f;

      // Power-up window
      if (!r.ready) begin
         n.pcnt = r.pcnt + 22'h1;
         if (r.pcnt == 22'(PWRUP_CYC - 1)) begin
            n.ready = 1'b1;  // RULE1
         end
      end

      // Clock-low counter, idle while disabled
      tout = 1'b0;
      if (!r.tout_en || n.scl_f) begin
         n.tcnt = 22'h0;  // RULE17
      end else if (r.tcnt == 22'(TOUT_CYC)) begin
         tout = 1'b1;  // RULE16
      end else begin
         n.tcnt = r.tcnt + 22'h1;
      end

      // Protocol engine
      case (r.st)
         // Address byte
         ST_ADDR: begin
            if (rise) begin
               n.sr  = {r.sr[6:0], n.sda_f};
               n.cnt = r.cnt + 4'h1;
            end else if (fall && r.cnt == 4'h8) begin
               if (r.ready && r.sr[7:1] == STP_DEV_ADDR) begin
                  n.st     = ST_AACK;  // RULE9
                  n.sda_oe = 1'b1;
                  n.is_ara = 1'b0;
                  n.rnw    = r.sr[0];
               end else if (r.ready && r.sr[7:1] == STP_ARA_ADDR && r.sr[0] && r.alert) begin
                  n.st     = ST_AACK;  // RULE12
                  n.sda_oe = 1'b1;
                  n.is_ara = 1'b1;
                  n.rnw    = 1'b1;
               end else begin
                  n.st = ST_WAIT;  // RULE3
               end
            end
         end
         // Address acknowledge, then turn to read or write
         ST_AACK: begin
            if (fall) begin
               n.cnt = 4'h0;
               if (r.rnw) begin
                  n.tx     = r.is_ara ? STP_ARA_RESP : reg_rdata_i;  // RULE8
                  n.rd     = ~r.is_ara;
                  n.sda_oe = r.is_ara ? ~STP_ARA_RESP[7] : ~reg_rdata_i[7];
                  n.st     = ST_TX;
               end else begin
                  n.sda_oe = 1'b0;
                  n.st     = ST_RX;
               end
            end
         end
         // Command or data byte from host
         ST_RX: begin
            if (rise) begin
               n.sr  = {r.sr[6:0], n.sda_f};
               n.cnt = r.cnt + 4'h1;
            end else if (fall && r.cnt == 4'h8) begin
               if (r.byte_idx == 2'd0) begin
                  n.ptr    = r.sr;  // RULE7 RULE20
                  n.sda_oe = 1'b1;
                  n.st     = ST_RACK;
               end else if (r.byte_idx == 2'd1) begin
                  n.wr     = 1'b1;  // RULE5
                  n.wdata  = r.sr;
                  n.sda_oe = 1'b1;
                  n.st     = ST_RACK;
               end else begin
                  n.st = ST_WAIT;  // RULE3
               end
            end
         end
         // Byte acknowledge
         ST_RACK: begin
            if (fall) begin
               n.sda_oe   = 1'b0;
               n.cnt      = 4'h0;
               n.byte_idx = r.byte_idx + 2'd1;
               n.st       = ST_RX;
            end
         end
         // Byte to host, each released one checked against the wire
         ST_TX: begin
            if (rise) begin
               if (!r.sda_oe && !n.sda_f) begin
                  n.st = ST_WAIT;  // RULE13
               end else begin
                  n.cnt = r.cnt + 4'h1;
               end
            end else if (fall) begin
               if (r.cnt == 4'h8) begin
                  n.sda_oe = 1'b0;
                  n.st     = ST_TACK;
               end else begin
                  n.tx     = {r.tx[6:0], 1'b0};  // RULE6
                  n.sda_oe = ~r.tx[6];
               end
            end
         end
         // Host acknowledge ends the single-byte read
         ST_TACK: begin
            if (rise) begin
               ara_done = r.is_ara;  // RULE14
               n.st     = ST_WAIT;
            end
         end
         // Idle and wait states only watch for START or STOP
         ST_IDLE, ST_WAIT: begin
            n.sda_oe = 1'b0;
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase

      // START restarts the engine, also as repeated START
      if (start) begin
         n.st       = ST_ADDR;  // RULE2
         n.cnt      = 4'h0;
         n.byte_idx = 2'd0;
         n.sda_oe   = 1'b0;
      end
      // STOP or timeout drops the transfer; pointer and registers stay
      if (stop || tout) begin
         n.st     = ST_IDLE;  // RULE19
         n.sda_oe = 1'b0;
         n.cnt    = 4'h0;
      end

      // Wishbone slave, one wait cycle, unmapped reads return zero
      bus_req = wb_i.cyc & wb_i.stb & ~r.wb_ack;
      if (bus_req) begin
         n.wb_ack = 1'b1;
         n.wb_dat = 32'h0;
         case (wb_i.adr)
            STP_REG_CTRL: begin
               n.wb_dat = {30'h0, r.mask, r.tout_en};
               if (wb_i.we && wb_i.sel[0]) begin
                  n.tout_en = wb_i.dat[STP_CTRL_TOUT];  // RULE17
                  n.mask    = wb_i.dat[STP_CTRL_MASK];
               end
            end
            STP_REG_STAT: begin
               n.wb_dat = {24'h0, r.status};
               if (wb_i.we && wb_i.sel[0]) begin
                  clr = wb_i.dat[7:0];
               end
            end
            STP_REG_PTR: begin
               n.wb_dat = {21'h0, r.st, r.ptr};
            end
            default: begin
               n.wb_dat = 32'h0;
            end
         endcase
      end
      // Hardware set wins over software clear; alert response keeps status
      n.status = (r.status & ~clr) | alert_event_i;  // RULE15 RULE18
      if (ara_done) begin
         n.mask = 1'b1;  // RULE14
      end
      n.alert = (|n.status) & ~n.mask;  // RULE10
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= STP_REGS_RST;
      end else begin
         r <= n;
      end
   end

   // Outputs straight from state
   assign wb_dat_o             = r.wb_dat;
   assign wb_ack_o             = r.wb_ack;
   assign serial_data_pin_o    = 1'b0;
   assign serial_data_pin_oe_o = r.sda_oe;
   assign alert_pin_o          = 1'b0;
   assign alert_pin_oe_o       = r.alert;
   assign reg_ptr_o            = r.ptr;
   assign reg_wr_o             = r.wr;
   assign reg_rd_o             = r.rd;
   assign reg_wdata_o          = r.wdata;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_pwrup;
      !r.ready |-> !r.sda_oe;
   endproperty
   a_pwrup: assert property (p_pwrup) else $error("ack inside power-up window"); // RULE1

   property p_bad_addr;
      (r.st == ST_ADDR && fall && r.cnt == 4'h8 && r.sr[7:1] != STP_DEV_ADDR
       && r.sr[7:1] != STP_ARA_ADDR && !start) |=> (r.st == ST_WAIT && !r.sda_oe);
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("foreign address taken"); // RULE3

   property p_ptr;
      (r.st == ST_RX && fall && r.cnt == 4'h8 && r.byte_idx == 2'd0)
         |=> (r.ptr == $past(r.sr) && !r.wr);
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer not loaded"); // RULE7

   property p_wr;
      r.wr |-> (r.byte_idx == 2'd1 && !r.is_ara) ##1 !r.wr;
   endproperty
   a_wr: assert property (p_wr) else $error("bad write strobe"); // RULE5

   property p_ara_mask;
      (r.st == ST_TACK && rise && r.is_ara) |=> r.mask ##1 !r.alert;
   endproperty
   a_ara_mask: assert property (p_ara_mask) else $error("mask not set after ARA"); // RULE14

   property p_tout;
      (r.tout_en && r.tcnt == 22'(TOUT_CYC) && !n.scl_f) |=> (r.st == ST_IDLE && !r.sda_oe);
   endproperty
   a_tout: assert property (p_tout) else $error("timeout ignored"); // RULE16

   property p_tout_off;
      !r.tout_en |=> (r.tcnt == 22'h0 || r.tout_en);
   endproperty
   a_tout_off: assert property (p_tout_off) else $error("timeout counts while off"); // RULE17

   property p_hold;
      (r.alert && !bus_req && !$rose(r.mask)) |=> (r.alert || r.mask);
   endproperty
   a_hold: assert property (p_hold) else $error("alert dropped on its own"); // RULE18

   property p_wb;
      bus_req |=> r.wb_ack ##1 !r.wb_ack;
   endproperty
   a_wb: assert property (p_wb) else $error("bus ack not one cycle"); // RULE2

endmodule : stp_smbus_target

/* verification/stp_host_model.sv */
/*
 SMBus host model: drives the bus clock and the data wire as enables.
 Assumes the bench resolves both open-drain wires with pull-ups.
*/
`timescale 1ns/1ns
module stp_host_model (
   // Clock and resolved data level
   input  wire logic clk_i,
   input  wire logic sda_i,
   // Open-drain enables, high pulls low
   output logic      scl_oe_o,
   output logic      sda_oe_o
);
   int lo_cyc = 6;  // Low span after data set, raised to stretch

   // Wires released, clock stands still while idle
   initial begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end

   // Wait whole system cycles
   task automatic hw(input int n);
      repeat (n) @(posedge clk_i);
   endtask : hw

   // START or repeated START
   task automatic start();
      sda_oe_o <= 1'b0;
      hw(8);
      scl_oe_o <= 1'b0;
      hw(8);
      sda_oe_o <= 1'b1;
      hw(8);
      scl_oe_o <= 1'b1;
   endtask : start

   // STOP, data rises while clock high
   task automatic stop();
      hw(2);
      sda_oe_o <= 1'b1;
      hw(lo_cyc);
      scl_oe_o <= 1'b0;
      hw(8);
      sda_oe_o <= 1'b0;
      hw(8);
   endtask : stop

   // One bit: data set while clock low, wire read at end of high
   task automatic bit_io(input logic b, output logic r);
      hw(2);
      sda_oe_o <= ~b;
      hw(lo_cyc);
      scl_oe_o <= 1'b0;
      hw(8);
      r = sda_i;
      scl_oe_o <= 1'b1;
   endtask : bit_io

   // Byte MSB first plus acknowledge bit, driven from a_in
   task automatic xfer(input logic [7:0] d, input logic a_in,
                       output logic [7:0] r, output logic a_out);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r[i]);
      end
      bit_io(a_in, a_out);
   endtask : xfer
endmodule : stp_host_model

/* verification/test_smbus_target_with_alert_response.sv */
/*
 Bench of the SMBus target: host model on the wires, a small register
 map behind the pointer, Wishbone tasks for the control registers.
 Assumes the design's own assertions guard the cycle timing.
*/
`timescale 1ns/1ns
module test_smbus_target_with_alert_response;
   import stp_pkg::*;
   localparam int PW = 400;  // Shortened power-up window
   localparam int TO = 200;  // Shortened clock-low timeout
   logic        clk_i, rst_i, scl_oe, sda_oe, dev_oe, alert_oe;
   logic        reg_wr, reg_rd;
   stp_wb_req_t wb_q;
   logic [31:0] wb_dat, rd;
   logic        wb_ack;
   logic [7:0]  reg_ptr, reg_wdata, alert_ev, regs [256];
   int          mismatches, total_checks;
   int          rd_cnt;                     // Register read strobes seen
   wire         scl = ~scl_oe;              // Pull-up on clock
   wire         sda = ~(sda_oe | dev_oe);   // Pull-up on data

   // Outer register map answers for the pointer
   always @(posedge clk_i) begin
      if (reg_wr) begin
         regs[reg_ptr] <= reg_wdata;
      end
   end

   // Count read strobes; alert responses must not raise one
   always @(posedge clk_i) begin
      if (reg_rd === 1'b1) begin
         rd_cnt <= rd_cnt + 1;
      end
   end

   stp_smbus_target #(.PWRUP_CYC(PW), .TOUT_CYC(TO)) u_stp_smbus_target (
      .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_q), .wb_dat_o(wb_dat),
      .wb_ack_o(wb_ack), .serial_clock_pin_i(scl), .serial_data_pin_i(sda),
      .serial_data_pin_o(), .serial_data_pin_oe_o(dev_oe), .alert_pin_o(),
      .alert_pin_oe_o(alert_oe), .reg_ptr_o(reg_ptr), .reg_wr_o(reg_wr),
      .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata),
      .reg_rdata_i(regs[reg_ptr]), .alert_event_i(alert_ev));
   stp_host_model u_stp_host_model (.clk_i(clk_i), .sda_i(sda),
      .scl_oe_o(scl_oe), .sda_oe_o(sda_oe));

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Classic Wishbone single cycle
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_q <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
      do @(posedge clk_i); while (wb_ack !== 1'b1);
      rd = wb_dat;
      wb_q <= '0;
   endtask : wb

   // Send a byte, expect an acknowledge level
   task automatic put(input logic [7:0] d, input logic ea);
      logic [7:0] r;
      logic a;
      u_stp_host_model.xfer(d, 1'b1, r, a);
      chk(32'(a), 32'(ea));
   endtask : put

   // Read a byte and NACK it
   task automatic get(input logic [7:0] e);
      logic [7:0] r;
      logic a;
      u_stp_host_model.xfer(8'hff, 1'b1, r, a);
      chk(32'(r), 32'(e));
   endtask : get

   // Command byte cut by a long clock-low spell
   task automatic tout_try(input logic [7:0] c, input logic ea);
      logic r;
      u_stp_host_model.start();
      put(8'h98, 1'b0);
      for (int i = 7; i >= 0; i--) begin
         u_stp_host_model.bit_io(c[i], r);
         if (i == 5) begin
            u_stp_host_model.hw(TO + 50);
         end
      end
      u_stp_host_model.bit_io(1'b1, r);
      chk(32'(r), 32'(ea));
      u_stp_host_model.stop();
   endtask : tout_try

   // Host traffic scenarios, one after another
   task automatic t_bus();
      u_stp_host_model.start();
      put(8'h98, 1'b1);
      u_stp_host_model.stop();
      u_stp_host_model.hw(PW);
      u_stp_host_model.start();
      put(8'h98, 1'b0);
      put(8'h05, 1'b0);
      put(8'ha5, 1'b0);
      u_stp_host_model.stop();
      chk(32'(regs[5]), 32'ha5);
      u_stp_host_model.start();
      put(8'h98, 1'b0);
      put(8'h06, 1'b0);
      u_stp_host_model.start();
      put(8'h99, 1'b0);
      get(8'hf9);
      u_stp_host_model.stop();
      wb(1'b0, STP_REG_PTR, '0);
      chk(rd, 32'h06);
      u_stp_host_model.start();
      put(8'h98, 1'b0);
      put(8'h03, 1'b0);
      u_stp_host_model.stop();
      wb(1'b0, STP_REG_PTR, '0);
      chk(rd, 32'h03);
      chk(32'(regs[3]), 32'hfc);
      for (int k = 0; k < 2; k++) begin
         u_stp_host_model.lo_cyc = 6 + 24 * k;  // Second pass stretched
         u_stp_host_model.start();
         put(8'h99, 1'b0);
         get(8'hfc);
         u_stp_host_model.stop();
      end
      u_stp_host_model.lo_cyc = 6;
      u_stp_host_model.start();
      put(8'h9a, 1'b1);
      put(8'h07, 1'b1);
      put(8'h00, 1'b1);
      u_stp_host_model.stop();
      chk(32'(regs[7]), 32'hf8);
      u_stp_host_model.start();
      put(8'h98, 1'b0);
      put(8'h07, 1'b0);
      put(8'h11, 1'b0);
      put(8'h22, 1'b1);
      u_stp_host_model.stop();
      chk(32'(regs[7]), 32'h11);
   endtask : t_bus

   // Alert response, arbitration loss, mask and status
   task automatic t_alert();
      logic [7:0] r;
      logic a;
      u_stp_host_model.start();
      put(8'h19, 1'b1);
      u_stp_host_model.stop();
      alert_ev <= 8'h01;
      @(posedge clk_i);
      alert_ev <= 8'h00;
      u_stp_host_model.hw(4);
      chk(32'(alert_oe), 32'h1);
      u_stp_host_model.start();
      put(8'h18, 1'b1);
      u_stp_host_model.stop();
      u_stp_host_model.start();
      put(8'h19, 1'b0);
      get(STP_ARA_RESP);
      u_stp_host_model.stop();
      chk(32'(alert_oe), 32'h0);
      wb(1'b0, STP_REG_STAT, '0);
      chk(rd, 32'h01);
      wb(1'b1, STP_REG_CTRL, '0);
      u_stp_host_model.hw(3);
      chk(32'(alert_oe), 32'h1);
      u_stp_host_model.start();
      put(8'h19, 1'b0);
      u_stp_host_model.xfer(8'h00, 1'b1, r, a);  // Host wins the first bit
      u_stp_host_model.stop();
      chk(32'(alert_oe), 32'h1);
      wb(1'b0, STP_REG_CTRL, '0);
      chk(rd, 32'h0);
      wb(1'b1, STP_REG_STAT, 32'hff);
      u_stp_host_model.hw(3);
      chk(32'(alert_oe), 32'h0);
      wb(1'b0, 8'h0c, '0);
      chk(rd, 32'h0);
   endtask : t_alert

   // Verdict and end of run
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done

   // Clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Watchdog against a hung wait
   initial begin
      repeat (60000) @(posedge clk_i);
      mismatches++;
      test_done();
   end

   // Reset, then the scenarios
   initial begin
      rst_i = 1'b1;
      wb_q = '0;
      alert_ev = 8'h00;
      mismatches = 0;
      total_checks = 0;
      rd_cnt = 0;
      for (int i = 0; i < 256; i++) begin
         regs[i] = ~8'(i);
      end
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      t_bus();
      t_alert();
      tout_try(8'h05, 1'b0);
      wb(1'b1, STP_REG_CTRL, 32'h1);
      tout_try(8'h03, 1'b1);
      wb(1'b0, STP_REG_PTR, '0);
      chk(rd, 32'h05);
      chk(32'(rd_cnt), 32'h3);
      test_done();
   end
endmodule : test_smbus_target_with_alert_response
